// ===== core/lcd_port_pkg.sv
// Constants for the character display host port: instruction codes, memory sizes,
// address map figures and timing counts.
// Assumes one core clock of 25 MHz.
package lcd_port_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned EXEC_TIME_NS   = 40000;
  localparam int unsigned EXEC_CYCLES    = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CHAR_TIME_NS   = 800;
  localparam int unsigned CHAR_CYCLES    = CHAR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned EXEC_W         = 10;
  localparam int unsigned CHAR_W         = 5;

  localparam int unsigned TEXT_DEPTH     = 80;
  localparam int unsigned GLYPH_DEPTH    = 64;
  localparam logic [6:0]  ONE_LINE_LAST  = 7'h4f;
  localparam logic [6:0]  LINE1_LAST     = 7'h27;
  localparam logic [6:0]  LINE2_BASE     = 7'h40;
  localparam logic [6:0]  LINE2_LAST     = 7'h67;
  localparam logic [6:0]  LINE_LEN       = 7'h28;
  localparam logic [6:0]  CHARS_PER_DRV  = 7'h08;
  localparam logic [3:0]  MAX_DRV_ONE    = 4'h9;
  localparam logic [3:0]  MAX_DRV_TWO    = 4'h4;

  // Instruction field positions
  localparam int unsigned BIT_SET_TEXT   = 7;
  localparam int unsigned BIT_SET_GLYPH  = 6;
  localparam int unsigned BIT_FUNC       = 5;
  localparam int unsigned BIT_SHIFT_OP   = 4;
  localparam int unsigned BIT_ENTRY      = 2;
  localparam int unsigned BIT_HOME       = 1;
  localparam int unsigned BIT_LINES      = 3;
  localparam int unsigned BIT_DISP_SEL   = 3;
  localparam int unsigned BIT_RIGHT      = 2;
  localparam int unsigned BIT_DIR_UP     = 1;

  localparam logic [7:0]  RESET_DATA     = 8'h00;
  localparam logic [6:0]  RESET_COUNTER  = 7'h00;
  localparam logic [6:0]  RESET_SHIFT    = 7'h00;
  localparam logic        RESET_DIR_UP   = 1'b1;
  localparam logic        RESET_TWO_LINE = 1'b0;

  localparam int unsigned FIFO_DEPTH     = 2;
  localparam int unsigned ENTRY_W        = 16;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_FETCH = 3'b100
  } op_state_t;
endpackage : lcd_port_pkg

// ===== core/lcd_host_port.sv
// Host port of a character display controller: instruction and data registers,
// busy flag, stepping address counter, text and glyph memories, refresh scan.
// Assumes host pins are asynchronous to mclk and strobes last several mclk cycles.
//
// Overview of operation
// [RULE1] Register select high picks the data register, low picks the instruction register.
// [RULE2] Read/write and register select give instruction write, status read, data write, data read.
// [RULE3] Instruction register is write only; a status read returns busy and counter.
// [RULE4] Each written data byte is copied into text or glyph memory at the counter.
// [RULE5] Setting an address fetches that memory byte into the data register.
// [RULE6] Each data write moves to the next memory location automatically.
// [RULE7] Each data read reloads the data register from the newly stepped address.
// [RULE8] Busy stays high during internal work; instructions issued meanwhile are discarded.
// [RULE9] A status read puts the busy flag on the top bus bit.
// [RULE10] The host polls status and issues instructions only while busy reads low.
// [RULE11] Counter bits on a status read are meaningless while busy is high.
// [RULE12] Address-set instructions choose text or glyph memory then load the counter.
// [RULE13] Every data access steps the counter by one in the chosen direction.
// [RULE14] A status read while idle puts the seven counter bits on bits zero to six.
// [RULE15] The counter also gives the cursor position.
// [RULE16] Host memory traffic is interleaved with refresh reads without disturbing them.
// [RULE17] Text memory holds eighty eight-bit character codes.
// [RULE18] One-line mode maps positions to consecutive addresses from 00; own outputs 00-07.
// [RULE19] One-line right shift shows 4F first, left shift shows 01 first.
// [RULE20] Two-line mode starts lines at 00 and 40; own outputs 00-07 and 40-47.
// [RULE21] Two-line lines span 00-27 and 40-67; shifting wraps inside each line.
// [RULE22] Expansion drivers add eight positions each, up to nine or four.
// [RULE23] Enable qualifies transfers; inputs latch at its fall, read data drives while high.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_port (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       enable_strobe,
  input  wire logic       read_not_write,
  input  wire logic       register_select,
  input  wire logic [7:0] host_bus_in,
  output logic      [7:0] host_bus_out,
  output logic            host_bus_oe,
  input  wire logic [3:0] expander_count,
  output logic      [7:0] scan_char,
  output logic      [6:0] scan_addr,
  output logic      [6:0] scan_pos,
  output logic            scan_line,
  output logic            scan_valid,
  output logic            expansion_shift_clock,
  output logic            lcd_alternation,
  output logic      [6:0] cursor_addr,
  output logic            cursor_in_glyph,
  output logic            busy_flag
);

  // Counter step with per-mode wrap
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                           input logic glyph, input logic two);
    logic [6:0] r;
    r = a;
    if (glyph) begin
      r = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
    end else if (!two) begin
      if (up) begin
        r = (a >= lcd_port_pkg::ONE_LINE_LAST) ? 7'h00 : a + 7'h01;
      end else begin
        r = (a == 7'h00) ? lcd_port_pkg::ONE_LINE_LAST : a - 7'h01;
      end
    end else if (up) begin
      if (a == lcd_port_pkg::LINE1_LAST) begin
        r = lcd_port_pkg::LINE2_BASE;
      end else if (a >= lcd_port_pkg::LINE2_LAST) begin
        r = 7'h00;
      end else begin
        r = a + 7'h01;
      end
    end else begin
      if (a == lcd_port_pkg::LINE2_BASE) begin
        r = lcd_port_pkg::LINE1_LAST;
      end else if (a == 7'h00) begin
        r = lcd_port_pkg::LINE2_LAST;
      end else begin
        r = a - 7'h01;
      end
    end
    return r;
  endfunction : step_addr

  // Display position to text address, shift applied inside the line
  function automatic logic [6:0] map_pos(input logic [6:0] pos, input logic line,
                                         input logic two, input logic [6:0] shift);
    logic [7:0] s;
    logic [7:0] lim;
    s = {1'b0, pos} + {1'b0, shift};
    lim = two ? {1'b0, lcd_port_pkg::LINE_LEN} : {1'b0, lcd_port_pkg::ONE_LINE_LAST} + 8'h01;
    if (s >= lim) begin
      s = s - lim;
    end
    if (two && line) begin
      return s[6:0] + lcd_port_pkg::LINE2_BASE;
    end
    return s[6:0];
  endfunction : map_pos

  // Text address to storage cell; two-line mode folds 40-67 onto 28-4F, one-line mode stays linear
  function automatic logic [6:0] text_index(input logic [6:0] a, input logic two);
    return (two && a >= lcd_port_pkg::LINE2_BASE) ? a - (lcd_port_pkg::LINE2_BASE - lcd_port_pkg::LINE_LEN) : a;
  endfunction : text_index

  // Pin synchronisers: first stage feeds only the second
  logic [10:0] pin_s1;
  logic [10:0] pin_s2;
  logic        e_d;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= 11'h000;
      pin_s2 <= 11'h000;
      e_d    <= 1'b0;
    end else begin
      pin_s1 <= {enable_strobe, read_not_write, register_select, host_bus_in};
      pin_s2 <= pin_s1;
      e_d    <= pin_s2[10];
    end
  end

  logic       e_high;
  logic       e_fall;
  logic       p_read;
  logic       p_data;
  logic [7:0] p_bus;
  assign e_high = pin_s2[10];
  assign e_fall = e_d & ~pin_s2[10]; // [RULE23]
  assign p_read = pin_s2[9];
  assign p_data = pin_s2[8];
  assign p_bus  = pin_s2[7:0];

  logic ev_instr;
  logic ev_status;
  logic ev_wdata;
  logic ev_rdata;
  assign ev_instr  = e_fall & ~p_read & ~p_data; // [RULE2]
  assign ev_status = e_fall &  p_read & ~p_data;
  assign ev_wdata  = e_fall & ~p_read &  p_data; // [RULE1]
  assign ev_rdata  = e_fall &  p_read &  p_data;

  // Memories
  logic [7:0] display_text_mem [lcd_port_pkg::TEXT_DEPTH];  // [RULE17]
  logic [7:0] user_glyph_mem   [lcd_port_pkg::GLYPH_DEPTH];

  // Two-entry write buffer {glyph, addr, data}; refresh slots stall its drain
  logic [lcd_port_pkg::ENTRY_W-1:0] fifo_mem [lcd_port_pkg::FIFO_DEPTH];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] fifo_cnt;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic       host_slot;

  // Control state
  lcd_port_pkg::op_state_t   state;
  logic [lcd_port_pkg::EXEC_W-1:0] exec_cnt;
  logic [6:0] addr_counter;
  logic       glyph_sel;
  logic       dir_up;
  logic       two_line;
  logic [6:0] disp_shift;
  logic       fetch_after;
  logic [7:0] data_transfer;

  assign fifo_in_ready  = (fifo_cnt != 2'h2);
  // Writes during internal work are dropped, so a stored byte and a counter step always pair
  assign fifo_in_valid  = ev_wdata & (state == lcd_port_pkg::ST_IDLE);
  assign fifo_out_valid = (fifo_cnt != 2'h0);
  assign fifo_out_ready = host_slot;  // [RULE16]
  assign busy_flag      = (state != lcd_port_pkg::ST_IDLE) | ~fifo_in_ready; // [RULE8]

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      fifo_cnt <= 2'd0;
    end else begin
      if (fifo_in_valid && fifo_in_ready) begin
        fifo_mem[wr_ptr] <= {glyph_sel, addr_counter, p_bus}; // [RULE4]
        wr_ptr <= ~wr_ptr;
      end
      if (fifo_out_valid && fifo_out_ready) begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_cnt <= fifo_cnt + {1'b0, fifo_in_valid & fifo_in_ready}
                           - {1'b0, fifo_out_valid & fifo_out_ready};
    end
  end

  // Buffer drain into memory on host slots only
  logic [lcd_port_pkg::ENTRY_W-1:0] head;
  assign head = fifo_mem[rd_ptr];
  always_ff @(posedge mclk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      if (head[15]) begin
        user_glyph_mem[head[13:8]] <= head[7:0]; // [RULE4]
      end else if (two_line ? (head[14:8] <= lcd_port_pkg::LINE1_LAST
                               || (head[14:8] >= lcd_port_pkg::LINE2_BASE && head[14:8] <= lcd_port_pkg::LINE2_LAST))
                            : head[14:8] <= lcd_port_pkg::ONE_LINE_LAST) begin
        display_text_mem[text_index(head[14:8], two_line)] <= head[7:0]; // [RULE17]
      end
    end
  end

  // Instruction execution, address counter and mode bits
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= lcd_port_pkg::ST_IDLE;
      exec_cnt     <= '0;
      addr_counter <= lcd_port_pkg::RESET_COUNTER;
      glyph_sel    <= 1'b0;
      dir_up       <= lcd_port_pkg::RESET_DIR_UP;
      two_line     <= lcd_port_pkg::RESET_TWO_LINE;
      disp_shift   <= lcd_port_pkg::RESET_SHIFT;
      fetch_after  <= 1'b0;
    end else begin
      case (state)
        lcd_port_pkg::ST_IDLE: begin
          if (ev_instr) begin // [RULE8]
            state       <= lcd_port_pkg::ST_EXEC;
            exec_cnt    <= lcd_port_pkg::EXEC_W'(lcd_port_pkg::EXEC_CYCLES - 1);
            fetch_after <= 1'b0;
            if (p_bus[lcd_port_pkg::BIT_SET_TEXT]) begin // [RULE12]
              glyph_sel    <= 1'b0;
              addr_counter <= p_bus[6:0];
              fetch_after  <= 1'b1; // [RULE5]
            end else if (p_bus[lcd_port_pkg::BIT_SET_GLYPH]) begin
              glyph_sel    <= 1'b1;
              addr_counter <= {1'b0, p_bus[5:0]};
              fetch_after  <= 1'b1;
            end else if (p_bus[lcd_port_pkg::BIT_FUNC]) begin
              two_line   <= p_bus[lcd_port_pkg::BIT_LINES];
              disp_shift <= lcd_port_pkg::RESET_SHIFT;
            end else if (p_bus[lcd_port_pkg::BIT_SHIFT_OP]) begin
              if (p_bus[lcd_port_pkg::BIT_DISP_SEL]) begin
                if (p_bus[lcd_port_pkg::BIT_RIGHT]) begin // [RULE19] [RULE21]
                  disp_shift <= (disp_shift == 7'h00)
                              ? (two_line ? lcd_port_pkg::LINE1_LAST : lcd_port_pkg::ONE_LINE_LAST)
                              : disp_shift - 7'h01;
                end else begin
                  disp_shift <= (disp_shift == (two_line ? lcd_port_pkg::LINE1_LAST
                                                         : lcd_port_pkg::ONE_LINE_LAST))
                              ? 7'h00 : disp_shift + 7'h01;
                end
              end else begin
                addr_counter <= step_addr(addr_counter, p_bus[lcd_port_pkg::BIT_RIGHT],
                                          glyph_sel, two_line);
              end
            end else if (p_bus[lcd_port_pkg::BIT_ENTRY]) begin
              dir_up <= p_bus[lcd_port_pkg::BIT_DIR_UP];
            end else if (p_bus[lcd_port_pkg::BIT_HOME]) begin
              glyph_sel    <= 1'b0;
              addr_counter <= lcd_port_pkg::RESET_COUNTER;
              disp_shift   <= lcd_port_pkg::RESET_SHIFT;
            end
          end else if (ev_wdata && fifo_in_ready) begin
            addr_counter <= step_addr(addr_counter, dir_up, glyph_sel, two_line); // [RULE6] [RULE13]
          end else if (ev_rdata) begin
            addr_counter <= step_addr(addr_counter, dir_up, glyph_sel, two_line); // [RULE13]
            state        <= lcd_port_pkg::ST_FETCH; // [RULE7]
          end
        end
        lcd_port_pkg::ST_EXEC: begin
          if (exec_cnt == '0) begin
            state <= fetch_after ? lcd_port_pkg::ST_FETCH : lcd_port_pkg::ST_IDLE;
          end else begin
            exec_cnt <= exec_cnt - 1'b1;
          end
        end
        lcd_port_pkg::ST_FETCH: begin
          // Wait for pending writes so the fetched byte is current
          if (!fifo_out_valid && host_slot) begin
            state <= lcd_port_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= lcd_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Data register: written byte, or memory byte on a fetch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_transfer <= lcd_port_pkg::RESET_DATA;
    end else if (fifo_in_valid && fifo_in_ready) begin
      data_transfer <= p_bus;
    end else if (state == lcd_port_pkg::ST_FETCH && !fifo_out_valid && host_slot) begin
      if (glyph_sel) begin
        data_transfer <= user_glyph_mem[addr_counter[5:0]]; // [RULE5] [RULE7]
      end else begin
        data_transfer <= display_text_mem[text_index(addr_counter, two_line)];
      end
    end
  end

  // Host read drive while enable is high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      host_bus_out <= 8'h00;
      host_bus_oe  <= 1'b0;
    end else begin
      host_bus_oe <= e_high & p_read; // [RULE23]
      if (p_data) begin
        host_bus_out <= data_transfer;
      end else begin
        // Counter is masked while busy since it may be mid-update
        host_bus_out <= {busy_flag, busy_flag ? 7'h00 : addr_counter}; // [RULE3] [RULE9] [RULE11] [RULE14]
      end
    end
  end

  assign cursor_addr     = addr_counter;  // [RULE15]
  assign cursor_in_glyph = glyph_sel;

  // Refresh scan: slot 0 is refresh, slot 1 host
  logic [lcd_port_pkg::CHAR_W-1:0] char_div;
  logic       char_tick;
  logic [6:0] pos;
  logic       line;
  logic [3:0] drv;
  logic [6:0] visible;
  logic [6:0] cur_addr;
  logic [6:0] cur_index;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      host_slot <= 1'b0;
      char_div  <= '0;
    end else begin
      host_slot <= ~host_slot;
      char_div  <= (char_div == lcd_port_pkg::CHAR_W'(lcd_port_pkg::CHAR_CYCLES - 1)) ? '0 : char_div + 1'b1;
    end
  end
  assign char_tick = (char_div == '0) && !host_slot; // [RULE16]

  always_comb begin
    drv = expander_count;
    if (!two_line && drv > lcd_port_pkg::MAX_DRV_ONE) begin
      drv = lcd_port_pkg::MAX_DRV_ONE;
    end else if (two_line && drv > lcd_port_pkg::MAX_DRV_TWO) begin
      drv = lcd_port_pkg::MAX_DRV_TWO;
    end
  end
  assign visible   = 7'(({3'b000, drv} + 7'h01) * lcd_port_pkg::CHARS_PER_DRV); // [RULE22]
  assign cur_addr  = map_pos(pos, line, two_line, disp_shift); // [RULE18] [RULE20] [RULE21]
  assign cur_index = text_index(cur_addr, two_line);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pos                   <= 7'h00;
      line                  <= 1'b0;
      scan_char             <= 8'h00;
      scan_addr             <= 7'h00;
      scan_pos              <= 7'h00;
      scan_line             <= 1'b0;
      scan_valid            <= 1'b0;
      expansion_shift_clock <= 1'b0;
      lcd_alternation       <= 1'b0;
    end else begin
      scan_valid            <= char_tick;
      expansion_shift_clock <= char_tick && (pos >= lcd_port_pkg::CHARS_PER_DRV); // [RULE22]
      if (char_tick) begin
        scan_char <= display_text_mem[cur_index];
        scan_addr <= cur_addr;
        scan_pos  <= pos;
        scan_line <= line;
        if (pos >= visible - 7'h01) begin
          pos <= 7'h00;
          if (two_line && !line) begin
            line <= 1'b1;
          end else begin
            line            <= 1'b0;
            lcd_alternation <= ~lcd_alternation;
          end
        end else begin
          pos <= pos + 7'h01;
        end
      end
    end
  end

endmodule : lcd_host_port
`default_nettype wire

// ===== testbench/lcd_port_monitor.sv
// Checker for the display host port, watching its top ports only.
// Assumes host pins stay steady for four mclk around each enable edge.
`timescale 1ns/1ps
`default_nettype none
module lcd_port_monitor (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       enable_strobe,
  input wire logic       read_not_write,
  input wire logic       register_select,
  input wire logic [7:0] host_bus_out,
  input wire logic       host_bus_oe,
  input wire logic       busy_flag,
  input wire logic [6:0] cursor_addr,
  input wire logic       scan_valid,
  input wire logic [6:0] scan_addr,
  input wire logic [6:0] scan_pos,
  input wire logic       scan_line,
  input wire logic       expansion_shift_clock,
  input wire logic       lcd_alternation
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  oe_on_read_a: assert property (
    host_bus_oe |-> $past(read_not_write, 3)) else $error("bus driven during a write");
  oe_after_enable_a: assert property (
    $rose(host_bus_oe) |-> $past(enable_strobe, 2) && $past(enable_strobe, 3)) else $error("bus driven without enable");
  busy_after_instr_a: assert property (
    $fell(enable_strobe) && !read_not_write && !register_select && !busy_flag |-> ##[1:6] busy_flag)
    else $error("instruction did not raise busy");
  busy_hides_count_a: assert property (
    host_bus_oe && !$past(register_select, 3) && host_bus_out[7] |-> host_bus_out[6:0] == 7'h00)
    else $error("counter shown while busy");
  idle_shows_count_a: assert property (
    host_bus_oe && !$past(register_select, 3) && !host_bus_out[7] |-> host_bus_out[6:0] == $past(cursor_addr))
    else $error("status counter differs from counter");
  scan_pulse_a: assert property (
    scan_valid |=> !scan_valid) else $error("refresh strobe longer than one cycle");
  shift_clk_a: assert property (
    expansion_shift_clock |-> scan_valid && scan_pos >= 7'h08) else $error("expansion clock outside expander range");
  first_line_a: assert property (
    scan_valid && !scan_line |-> scan_addr <= 7'h4f) else $error("first line address out of range");
  second_line_a: assert property (
    scan_valid && scan_line |-> scan_addr >= 7'h40 && scan_addr <= 7'h67) else $error("second line address out of range");
  frame_flip_a: assert property (
    $changed(lcd_alternation) |-> scan_valid) else $error("alternation changed outside a refresh strobe");
endmodule : lcd_port_monitor

bind lcd_host_port lcd_port_monitor mon (
  .mclk(mclk), .arst_n(arst_n), .enable_strobe(enable_strobe), .read_not_write(read_not_write),
  .register_select(register_select), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
  .busy_flag(busy_flag), .cursor_addr(cursor_addr), .scan_valid(scan_valid), .scan_addr(scan_addr),
  .scan_pos(scan_pos), .scan_line(scan_line), .expansion_shift_clock(expansion_shift_clock),
  .lcd_alternation(lcd_alternation));
`default_nettype wire

// ===== testbench/lcd_host_cpu.sv
// Host processor model: byte transfers on the parallel port and busy polling.
// Assumes pull-ups on the select and data pins once released.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_cpu (
  input  wire logic       mclk,
  output logic            enable_strobe,
  output logic            read_not_write,
  output logic            register_select,
  output logic      [7:0] host_bus_in,
  input  wire logic [7:0] host_bus_out,
  input  wire logic       host_bus_oe
);
  logic        drive;
  logic [7:0]  wdata;
  int unsigned hold_extra;
  // Released lines float to the pull-up level
  assign host_bus_in = host_bus_oe ? host_bus_out : (drive ? wdata : 8'hff);
  initial begin
    enable_strobe   = 1'b0;
    read_not_write  = 1'b1;
    register_select = 1'b1;
    drive           = 1'b0;
    wdata           = 8'h00;
    hold_extra      = 0;
  end
  // Four cycles of setup and five of hold cover the synchroniser and edge detect
  task automatic xfer(input logic rw, input logic rs, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk);
    #1;
    read_not_write  = rw;
    register_select = rs;
    wdata           = wd;
    drive           = !rw;
    repeat (4) @(posedge mclk);
    #1;
    enable_strobe = 1'b1;
    repeat (8 + hold_extra) @(posedge mclk);
    #1;
    rd = host_bus_in;
    enable_strobe = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    read_not_write  = 1'b1;
    register_select = 1'b1;
    drive           = 1'b0;
  endtask : xfer
  // Counter bits are trusted only from a poll that shows busy low
  task automatic wait_ready(output logic [7:0] st, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      xfer(1'b1, 1'b0, 8'h00, st);
      ok = (st[7] === 1'b0);
    end
  endtask : wait_ready
endmodule : lcd_host_cpu
`default_nettype wire

// ===== testbench/char_lcd_host_port_addr_map_bench.sv
// Self-checking bench for the display host port.
// Assumes the host model lcd_host_cpu and the bound checker lcd_port_monitor.
`timescale 1ns/1ps
`default_nettype none
module char_lcd_host_port_addr_map_bench;
  logic        mclk, arst_n, enable_strobe, read_not_write, register_select, host_bus_oe;
  logic        scan_line, scan_valid, cursor_in_glyph, busy_flag, ok;
  logic [7:0]  host_bus_in, host_bus_out, scan_char, st, rdv;
  logic [6:0]  scan_addr, scan_pos, cursor_addr;
  logic [3:0]  expander_count;
  int unsigned failures = 0;
  int unsigned n_checks = 0;
  int unsigned cyc = 0;
  int unsigned t0;

  lcd_host_port dut (
    .mclk(mclk), .arst_n(arst_n), .enable_strobe(enable_strobe), .read_not_write(read_not_write),
    .register_select(register_select), .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe), .expander_count(expander_count), .scan_char(scan_char),
    .scan_addr(scan_addr), .scan_pos(scan_pos), .scan_line(scan_line), .scan_valid(scan_valid),
    .expansion_shift_clock(), .lcd_alternation(), .cursor_addr(cursor_addr),
    .cursor_in_glyph(cursor_in_glyph), .busy_flag(busy_flag));
  lcd_host_cpu cpu (
    .mclk(mclk), .enable_strobe(enable_strobe), .read_not_write(read_not_write),
    .register_select(register_select), .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // Instruction followed by polling, as a well-behaved host does
  task automatic cmd(input logic [7:0] code);
    cpu.xfer(1'b0, 1'b0, code, rdv);
    cpu.wait_ready(st, ok);
    check("ready", {7'h00, ok}, 8'h01);
  endtask : cmd
  task automatic wr(input logic [7:0] d);
    cpu.xfer(1'b0, 1'b1, d, rdv);
  endtask : wr
  task automatic rd;
    cpu.xfer(1'b1, 1'b1, 8'h00, rdv);
  endtask : rd
  task automatic scan_at(input logic [6:0] pos, input logic line, input logic [6:0] addr, input logic [7:0] chr);
    int n;
    n = 0;
    while (!(scan_valid === 1'b1 && scan_pos === pos && scan_line === line) && n < 4000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("scan seen", {7'h00, n < 4000}, 8'h01);
    check("scan address", {1'b0, scan_addr}, {1'b0, addr});
    check("scan char", scan_char, chr);
  endtask : scan_at

  task automatic t_reset_state;
    cpu.xfer(1'b1, 1'b0, 8'h00, st);
    check("status after reset", st, 8'h00);
  endtask : t_reset_state
  task automatic t_address_set;
    cpu.xfer(1'b0, 1'b0, 8'h90, rdv);
    t0 = cyc;
    check("busy pin", {7'h00, busy_flag}, 8'h01);
    cpu.xfer(1'b1, 1'b0, 8'h00, st);
    check("status while busy", st, 8'h80);
    cpu.wait_ready(st, ok);
    check("busy span", {7'h00, (cyc - t0) >= 1000}, 8'h01);
    check("counter loaded", st, 8'h10);
    check("cursor", {cursor_in_glyph, cursor_addr}, 8'h10);
    // A second instruction while busy must vanish
    cpu.xfer(1'b0, 1'b0, 8'ha0, rdv);
    cpu.xfer(1'b0, 1'b0, 8'hb0, rdv);
    cpu.wait_ready(st, ok);
    check("late instruction dropped", st, 8'h20);
  endtask : t_address_set
  task automatic t_write_read;
    cmd(8'h90);
    wr(8'h11);
    wr(8'h22);
    wr(8'h33);
    cpu.wait_ready(st, ok);
    check("counter after writes", st, 8'h13);
    cmd(8'h90);
    rd;
    check("fetched byte", rdv, 8'h11);
    rd;
    check("next byte", rdv, 8'h22);
    cpu.wait_ready(st, ok);
    check("counter after reads", st, 8'h12);
    cmd(8'h04);
    cmd(8'h93);
    wr(8'h44);
    cpu.wait_ready(st, ok);
    check("counter stepped down", st, 8'h12);
    cmd(8'h93);
    rd;
    check("down write stored", rdv, 8'h44);
    cmd(8'h06);
  endtask : t_write_read
  task automatic t_glyph;
    cmd(8'h45);
    check("glyph cursor", {cursor_in_glyph, cursor_addr}, 8'h85);
    wr(8'h1f);
    cmd(8'h45);
    rd;
    check("glyph byte", rdv, 8'h1f);
    cmd(8'h02);
    cmd(8'h14);
    check("home then move", {cursor_in_glyph, cursor_addr}, 8'h01);
  endtask : t_glyph
  task automatic t_scan_one;
    cmd(8'hc0);
    wr(8'h4d);
    cmd(8'ha8);
    wr(8'h28);
    cmd(8'hc0);
    rd;
    check("one-line distinct cells", rdv, 8'h4d);
    cmd(8'hcf);
    wr(8'ha5);
    wr(8'h5a);
    wr(8'h3c);
    cpu.wait_ready(st, ok);
    check("one-line wrap", st, 8'h02);
    scan_at(7'h00, 1'b0, 7'h00, 8'h5a);
    cmd(8'h1c);
    scan_at(7'h00, 1'b0, 7'h4f, 8'ha5);
    cmd(8'h18);
    cmd(8'h18);
    scan_at(7'h00, 1'b0, 7'h01, 8'h3c);
  endtask : t_scan_one
  task automatic t_scan_two;
    expander_count = 4'h2;
    cmd(8'h28);
    cmd(8'hc0);
    wr(8'h77);
    cmd(8'ha7);
    wr(8'h61);
    cpu.wait_ready(st, ok);
    check("two-line step", st, 8'h40);
    cmd(8'he7);
    wr(8'h62);
    scan_at(7'h00, 1'b1, 7'h40, 8'h77);
    cmd(8'h1c);
    scan_at(7'h00, 1'b0, 7'h27, 8'h61);
    scan_at(7'h00, 1'b1, 7'h67, 8'h62);
  endtask : t_scan_two

  initial begin
    arst_n         = 1'b0;
    expander_count = 4'h1;
    repeat (16) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    t_reset_state;
    t_address_set;
    t_write_read;
    t_glyph;
    t_scan_one;
    t_scan_two;
    report_and_stop;
  end
  // Longest legal run is well under this span
  initial begin
    #(100000 * 40);
    failures++;
    $display("[FAIL] watchdog expected done seen hang");
    report_and_stop;
  end
endmodule : char_lcd_host_port_addr_map_bench
`default_nettype wire
